// ==== core/frf_top.sv ====
// Register storage of the floating-point coprocessor: general registers, pair
// views, control moves and the drain before a status read.
// Assumes the integer core drives every request from logic on mclk.
//
// Behaviour
// - There are thirty-two 32-bit general registers, each chosen by a 5-bit number.
// - Each general register can be read or written alone by moves, loads and stores.
// - Sixteen 64-bit logical registers are formed by joining two neighbouring registers.
// - Logical registers are selected by even numbers only; odd numbers are refused and flagged on pair_addr_err.
// - In double format logical register 2n takes register 2n low and 2n+1 high.
// - In single format only the even, lower register of the pair is read or written.
// - Each logical register holds a single or double value as the operation's format says.
// - Control space has 32 numbers, two implemented, reached only by control moves.
// - Control register 31 is the 32-bit status register with exceptions, compare and rounding.
// - Control register 0 reads back the implementation and revision codes.
// - Loads and stores finish in one cycle and operations start in one and overlap.
// - A status read first waits for every outstanding operation to finish or for a trapping result, which aborts it on ctl_rd_abort.
module frf_top #(
  parameter int PEND_W = 4,
  // Identification codes; the values are arbitrary.
  parameter logic [7:0] IMPL_CODE = 8'h5a,
  parameter logic [7:0] REV_CODE = 8'h01
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Single general register writes from loads and moves
  input wire logic gr_wr_en,
  input wire logic [4:0] gr_wr_addr,
  input wire logic [31:0] gr_wr_data,
  // Single general register reads for stores and moves
  input wire logic gr_rd_en,
  input wire logic [4:0] gr_rd_addr,
  output logic [31:0] gr_rd_data,
  output logic gr_rd_valid,
  // Operation issue and operand fetch
  input wire logic op_issue,
  input wire frf_pkg::frf_fmt_t op_fmt,
  input wire logic [4:0] op_src_a,
  input wire logic [4:0] op_src_b,
  output logic op_ready,
  output logic [63:0] opa_data,
  output logic [63:0] opb_data,
  output logic op_valid,
  // Operation results
  input wire logic res_valid,
  input wire frf_pkg::frf_fmt_t res_fmt,
  input wire logic [4:0] res_dst,
  input wire logic [63:0] res_data,
  input wire logic [5:0] res_exc,
  input wire logic res_cmp_valid,
  input wire logic res_cmp,
  // Control register moves
  input wire logic ctl_wr_en,
  input wire logic [4:0] ctl_wr_addr,
  input wire logic [31:0] ctl_wr_data,
  input wire logic ctl_rd_en,
  input wire logic [4:0] ctl_rd_addr,
  output logic [31:0] ctl_rd_data,
  output logic ctl_rd_valid,
  output logic ctl_rd_abort,
  output logic ctl_busy,
  // Status to the datapath and core
  output logic pair_addr_err,
  output logic [1:0] round_mode,
  output logic cond_out,
  output logic fp_trap
);
  frf_core_if bus ();

  frf_pkg::frf_crd_state_t crd_state_r;
  frf_pkg::frf_crd_state_t crd_state_nxt;
  logic [PEND_W-1:0] pend_r;
  logic [PEND_W-1:0] pend_nxt;
  logic [31:0] ctl_rd_data_r;
  logic [31:0] ctl_rd_data_nxt;
  logic ctl_rd_abort_r;
  logic ctl_rd_abort_nxt;
  logic [31:0] gr_rd_data_r;
  logic [31:0] gr_rd_data_nxt;
  logic gr_rd_valid_r;
  logic gr_rd_valid_nxt;
  logic [63:0] opa_r;
  logic [63:0] opa_nxt;
  logic [63:0] opb_r;
  logic [63:0] opb_nxt;
  logic op_valid_r;
  logic op_valid_nxt;
  logic pair_err_r;
  logic pair_err_nxt;
  logic [4:0] ctl_rd_sel_r;
  logic [4:0] ctl_rd_sel_nxt;
  logic issue_ok;
  logic res_ok;
  logic res_traps;
  logic [31:0] impl_word;
  logic [4:0] cs_en;

  frf_bank u_bank (
    .mclk(mclk),
    .rst(rst),
    .bus(bus)
  );

  frf_status u_status (
    .mclk(mclk),
    .rst(rst),
    .bus(bus)
  );

  // Operand and result selection on logical registers must use even numbers.
  assign issue_ok = op_issue && op_ready && !op_src_a[0] && !op_src_b[0];
  assign res_ok = res_valid && !res_cmp_valid && !res_dst[0];
  assign cs_en = bus.cs_q[frf_pkg::CS_EN_LSB +: frf_pkg::CS_FLAG_W];
  assign res_traps = res_valid
    && (res_exc[frf_pkg::CAUSE_UNIMPL_BIT] || (|(res_exc[frf_pkg::CS_FLAG_W-1:0] & cs_en)));
  assign impl_word = (32'(IMPL_CODE) << frf_pkg::IMPL_LSB)
    | (32'(REV_CODE) << frf_pkg::REV_LSB);

  // Storage side.
  always_comb
  begin
    bus.ld_we = gr_wr_en;
    bus.ld_addr = gr_wr_addr;
    bus.ld_data = gr_wr_data;
    bus.sr_addr = gr_rd_addr;
    bus.pa_idx = op_src_a[4:1];
    bus.pb_idx = op_src_b[4:1];
    bus.rs_pair = res_dst[4:1];
    bus.rs_lo = res_data[31:0];
    bus.rs_hi = res_data[63:32];
    bus.rs_lo_we = res_ok;
    bus.rs_hi_we = res_ok && (res_fmt == frf_pkg::FRF_FMT_DOUBLE);
  end

  // Status side.
  always_comb
  begin
    bus.cs_we = ctl_wr_en && (ctl_wr_addr == frf_pkg::CTRL_STATUS_NUM);
    bus.cs_wdata = ctl_wr_data;
    bus.cs_res_valid = res_valid;
    bus.cs_exc = res_exc;
    bus.cs_cmp_valid = res_valid && res_cmp_valid;
    bus.cs_cmp = res_cmp;
  end

  // Outstanding operation count: issue adds one, each result retires one.
  always_comb
  begin
    pend_nxt = pend_r;
    if (issue_ok && !res_valid)
    begin
      pend_nxt = pend_r + PEND_W'(1);
    end
    else if (!issue_ok && res_valid && (pend_r != '0))
    begin
      pend_nxt = pend_r - PEND_W'(1);
    end
  end

  // Single register reads and operand fetch, answered one cycle later.
  always_comb
  begin
    gr_rd_valid_nxt = gr_rd_en;
    gr_rd_data_nxt = gr_rd_data_r;
    if (gr_rd_en)
    begin
      gr_rd_data_nxt = bus.sr_data;
    end
    op_valid_nxt = issue_ok;
    opa_nxt = opa_r;
    opb_nxt = opb_r;
    if (issue_ok)
    begin
      if (op_fmt == frf_pkg::FRF_FMT_DOUBLE)
      begin
        opa_nxt = bus.pa_data;
        opb_nxt = bus.pb_data;
      end
      else
      begin
        opa_nxt = {32'h0000_0000, bus.pa_data[31:0]};
        opb_nxt = {32'h0000_0000, bus.pb_data[31:0]};
      end
    end
    pair_err_nxt = (op_issue && (op_src_a[0] || op_src_b[0]))
      || (res_valid && !res_cmp_valid && res_dst[0]);
  end

  // Control reads: the status register waits for the pipeline to empty.
  always_comb
  begin
    crd_state_nxt = crd_state_r;
    ctl_rd_data_nxt = ctl_rd_data_r;
    ctl_rd_sel_nxt = ctl_rd_sel_r;
    ctl_rd_abort_nxt = 1'b0;
    case (crd_state_r)
      frf_pkg::FRF_CR_IDLE:
      begin
        if (ctl_rd_en)
        begin
          ctl_rd_sel_nxt = ctl_rd_addr;
          if (ctl_rd_addr == frf_pkg::CTRL_STATUS_NUM)
          begin
            crd_state_nxt = frf_pkg::FRF_CR_DRAIN;
          end
          else
          begin
            crd_state_nxt = frf_pkg::FRF_CR_RESP;
            if (ctl_rd_addr == frf_pkg::CTRL_IMPL_NUM)
            begin
              ctl_rd_data_nxt = impl_word;
            end
            else
            begin
              ctl_rd_data_nxt = frf_pkg::CTRL_UNUSED_VALUE;
            end
          end
        end
      end
      frf_pkg::FRF_CR_DRAIN:
      begin
        // A trapping result while emptying ends the read; the core retries it.
        if (res_traps)
        begin
          crd_state_nxt = frf_pkg::FRF_CR_IDLE;
          ctl_rd_abort_nxt = 1'b1;
        end
        else if (pend_r == '0)
        begin
          crd_state_nxt = frf_pkg::FRF_CR_RESP;
          ctl_rd_data_nxt = bus.cs_q;
        end
      end
      frf_pkg::FRF_CR_RESP:
      begin
        crd_state_nxt = frf_pkg::FRF_CR_IDLE;
      end
      default:
      begin
        crd_state_nxt = frf_pkg::FRF_CR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      crd_state_r <= frf_pkg::FRF_CR_IDLE;
      pend_r <= '0;
      ctl_rd_data_r <= '0;
      ctl_rd_sel_r <= '0;
      ctl_rd_abort_r <= 1'b0;
      gr_rd_data_r <= '0;
      gr_rd_valid_r <= 1'b0;
      opa_r <= '0;
      opb_r <= '0;
      op_valid_r <= 1'b0;
      pair_err_r <= 1'b0;
    end
    else
    begin
      crd_state_r <= crd_state_nxt;
      pend_r <= pend_nxt;
      ctl_rd_data_r <= ctl_rd_data_nxt;
      ctl_rd_sel_r <= ctl_rd_sel_nxt;
      ctl_rd_abort_r <= ctl_rd_abort_nxt;
      gr_rd_data_r <= gr_rd_data_nxt;
      gr_rd_valid_r <= gr_rd_valid_nxt;
      opa_r <= opa_nxt;
      opb_r <= opb_nxt;
      op_valid_r <= op_valid_nxt;
      pair_err_r <= pair_err_nxt;
    end
  end

  assign op_ready = ~(&pend_r);
  assign gr_rd_data = gr_rd_data_r;
  assign gr_rd_valid = gr_rd_valid_r;
  assign opa_data = opa_r;
  assign opb_data = opb_r;
  assign op_valid = op_valid_r;
  assign ctl_rd_data = ctl_rd_data_r;
  assign ctl_rd_valid = (crd_state_r == frf_pkg::FRF_CR_RESP);
  assign ctl_rd_abort = ctl_rd_abort_r;
  assign ctl_busy = (crd_state_r != frf_pkg::FRF_CR_IDLE);
  assign pair_addr_err = pair_err_r;
  assign round_mode = bus.cs_q[frf_pkg::CS_RM_LSB +: frf_pkg::CS_RM_W];
  assign cond_out = bus.cs_q[frf_pkg::CS_COND_BIT];
  assign fp_trap = bus.cs_trap;
endmodule

// ==== shared/frf_pkg.sv ====
// Constants and types of the floating-point register file.
// Assumes every user names items as frf_pkg::name, with no import.
package frf_pkg;
  localparam int GR_NUM = 32;
  localparam int GR_W = 32;
  localparam int GR_AW = 5;
  localparam int PAIR_AW = 4;
  localparam int PAIR_W = 64;
  localparam int CTRL_AW = 5;
  localparam logic [31:0] GR_RESET = 32'h0000_0000;
  // Control register numbers.
  localparam logic [4:0] CTRL_IMPL_NUM = 5'h00;
  localparam logic [4:0] CTRL_STATUS_NUM = 5'h1f;
  // Control/status field layout.
  localparam int CS_COND_BIT = 23;
  localparam int CS_CAUSE_LSB = 12;
  localparam int CS_CAUSE_W = 6;
  localparam int CS_EN_LSB = 7;
  localparam int CS_STICKY_LSB = 2;
  localparam int CS_FLAG_W = 5;
  localparam int CS_RM_LSB = 0;
  localparam int CS_RM_W = 2;
  localparam int CAUSE_UNIMPL_BIT = 5;
  localparam logic [31:0] CS_WRITE_MASK = 32'h0083_ffff;
  localparam logic [31:0] CS_RESET = 32'h0000_0000;
  // Implementation/revision field layout.
  localparam int IMPL_LSB = 8;
  localparam int REV_LSB = 0;
  localparam logic [31:0] CTRL_UNUSED_VALUE = 32'h0000_0000;

  typedef enum logic {FRF_FMT_SINGLE = 1'b0, FRF_FMT_DOUBLE = 1'b1} frf_fmt_t;

  typedef enum logic [2:0] {
    FRF_CR_IDLE = 3'b001,
    FRF_CR_DRAIN = 3'b010,
    FRF_CR_RESP = 3'b100
  } frf_crd_state_t;
endpackage

// ==== shared/frf_core_if.sv ====
// Signals between the register file top and its storage and status modules.
// Assumes the package frf_pkg is compiled first.
interface frf_core_if;
  logic ld_we;
  logic [4:0] ld_addr;
  logic [31:0] ld_data;
  logic rs_lo_we;
  logic rs_hi_we;
  logic [3:0] rs_pair;
  logic [31:0] rs_lo;
  logic [31:0] rs_hi;
  logic [4:0] sr_addr;
  logic [31:0] sr_data;
  logic [3:0] pa_idx;
  logic [3:0] pb_idx;
  logic [63:0] pa_data;
  logic [63:0] pb_data;
  logic cs_we;
  logic [31:0] cs_wdata;
  logic cs_res_valid;
  logic [5:0] cs_exc;
  logic cs_cmp_valid;
  logic cs_cmp;
  logic [31:0] cs_q;
  logic cs_trap;

  modport top (
    output ld_we, ld_addr, ld_data, rs_lo_we, rs_hi_we, rs_pair, rs_lo, rs_hi,
    output sr_addr, pa_idx, pb_idx, cs_we, cs_wdata, cs_res_valid, cs_exc,
    output cs_cmp_valid, cs_cmp,
    input sr_data, pa_data, pb_data, cs_q, cs_trap
  );
  modport bank (
    input ld_we, ld_addr, ld_data, rs_lo_we, rs_hi_we, rs_pair, rs_lo, rs_hi,
    input sr_addr, pa_idx, pb_idx,
    output sr_data, pa_data, pb_data
  );
  modport status (
    input cs_we, cs_wdata, cs_res_valid, cs_exc, cs_cmp_valid, cs_cmp,
    output cs_q, cs_trap
  );
endinterface

// ==== core/frf_bank.sv ====
// Storage of the thirty-two general registers and their pair views.
// Assumes one write port per source; the single-word port wins a clash.
module frf_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register traffic
  frf_core_if.bank bus
);
  logic [31:0] float_general_reg_r [frf_pkg::GR_NUM];
  logic [31:0] float_general_reg_nxt [frf_pkg::GR_NUM];

  always_comb
  begin
    float_general_reg_nxt = float_general_reg_r;
    // Pair halves are written on their own so a single result keeps the upper half.
    if (bus.rs_lo_we)
    begin
      float_general_reg_nxt[{bus.rs_pair, 1'b0}] = bus.rs_lo;
    end
    if (bus.rs_hi_we)
    begin
      float_general_reg_nxt[{bus.rs_pair, 1'b1}] = bus.rs_hi;
    end
    if (bus.ld_we)
    begin
      float_general_reg_nxt[bus.ld_addr] = bus.ld_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      float_general_reg_r <= '{default: frf_pkg::GR_RESET};
    end
    else
    begin
      float_general_reg_r <= float_general_reg_nxt;
    end
  end

  assign bus.sr_data = float_general_reg_r[bus.sr_addr];
  // Each logical register is the concatenation of two neighbours, most half odd.
  assign bus.pa_data = {float_general_reg_r[{bus.pa_idx, 1'b1}],
                        float_general_reg_r[{bus.pa_idx, 1'b0}]};
  assign bus.pb_data = {float_general_reg_r[{bus.pb_idx, 1'b1}],
                        float_general_reg_r[{bus.pb_idx, 1'b0}]};
endmodule

// ==== core/frf_status.sv ====
// The control/status register: condition, cause, enables, sticky flags, rounding.
// Assumes results and control writes arrive as one-cycle strobes.
module frf_status (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Status traffic
  frf_core_if.status bus
);
  logic [31:0] float_ctrl_status_r;
  logic [31:0] float_ctrl_status_nxt;
  logic [4:0] sticky;

  always_comb
  begin
    float_ctrl_status_nxt = float_ctrl_status_r;
    sticky = float_ctrl_status_r[frf_pkg::CS_STICKY_LSB +: frf_pkg::CS_FLAG_W];
    if (bus.cs_we)
    begin
      float_ctrl_status_nxt = bus.cs_wdata & frf_pkg::CS_WRITE_MASK;
      sticky = bus.cs_wdata[frf_pkg::CS_STICKY_LSB +: frf_pkg::CS_FLAG_W];
    end
    if (bus.cs_res_valid)
    begin
      // A new exception sets its sticky flag even when software clears it now.
      float_ctrl_status_nxt[frf_pkg::CS_CAUSE_LSB +: frf_pkg::CS_CAUSE_W] = bus.cs_exc;
      sticky = sticky | bus.cs_exc[frf_pkg::CS_FLAG_W-1:0];
    end
    float_ctrl_status_nxt[frf_pkg::CS_STICKY_LSB +: frf_pkg::CS_FLAG_W] = sticky;
    if (bus.cs_cmp_valid)
    begin
      float_ctrl_status_nxt[frf_pkg::CS_COND_BIT] = bus.cs_cmp;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      float_ctrl_status_r <= frf_pkg::CS_RESET;
    end
    else
    begin
      float_ctrl_status_r <= float_ctrl_status_nxt;
    end
  end

  assign bus.cs_q = float_ctrl_status_r;
  // The unimplemented-operation cause always traps; the others only when enabled.
  assign bus.cs_trap = float_ctrl_status_r[frf_pkg::CS_CAUSE_LSB + frf_pkg::CAUSE_UNIMPL_BIT]
    | (|(float_ctrl_status_r[frf_pkg::CS_CAUSE_LSB +: frf_pkg::CS_FLAG_W]
         & float_ctrl_status_r[frf_pkg::CS_EN_LSB +: frf_pkg::CS_FLAG_W]));
endmodule

// ==== test/frf_top_asserts.sv ====
// Concurrent checks on the ports of the floating-point register file top.
// Assumes it is bound into frf_top and sees nothing but that module's ports.
module frf_top_asserts #(
  parameter logic [7:0] IMPL_CODE = 8'h5a,
  parameter logic [7:0] REV_CODE = 8'h01
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // General reads and operations
  input wire logic gr_rd_en,
  input wire logic gr_rd_valid,
  input wire logic op_issue,
  input wire logic op_ready,
  input wire frf_pkg::frf_fmt_t op_fmt,
  input wire logic [4:0] op_src_a,
  input wire logic [4:0] op_src_b,
  input wire logic [63:0] opa_data,
  input wire logic [63:0] opb_data,
  input wire logic op_valid,
  input wire logic pair_addr_err,
  input wire logic res_valid,
  input wire logic res_cmp_valid,
  input wire logic res_cmp,
  // Control moves and status
  input wire logic ctl_wr_en,
  input wire logic [4:0] ctl_wr_addr,
  input wire logic [31:0] ctl_wr_data,
  input wire logic ctl_rd_en,
  input wire logic [4:0] ctl_rd_addr,
  input wire logic [31:0] ctl_rd_data,
  input wire logic ctl_rd_valid,
  input wire logic ctl_busy,
  input wire logic [1:0] round_mode,
  input wire logic cond_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic crd;
  assign take = op_issue && op_ready && !op_src_a[0] && !op_src_b[0];
  assign crd = ctl_rd_en && !ctl_busy;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_rd_answer: assert property (gr_rd_en |=> gr_rd_valid)
    else $error("general read not answered in one cycle");
  a_issue_answer: assert property (take |=> op_valid)
    else $error("accepted issue gave no operands next cycle");
  a_odd_refused: assert property (op_issue && (op_src_a[0] || op_src_b[0])
    |=> pair_addr_err && !op_valid)
    else $error("odd pair number not refused");
  a_single_upper: assert property (take && op_fmt == frf_pkg::FRF_FMT_SINGLE
    |=> opa_data[63:32] == 32'h0 && opb_data[63:32] == 32'h0)
    else $error("single operand upper half not zero");
  a_impl_read: assert property (crd && ctl_rd_addr == 5'h00
    |=> ctl_rd_valid && ctl_rd_data == {16'h0000, IMPL_CODE, REV_CODE})
    else $error("identity read wrong");
  a_unimpl_read: assert property (crd && ctl_rd_addr != 5'h00 && ctl_rd_addr != 5'h1f
    |=> ctl_rd_valid && ctl_rd_data == 32'h0)
    else $error("unused control number not read as zero");
  a_status_drain: assert property (crd && ctl_rd_addr == 5'h1f
    |=> ctl_busy && !ctl_rd_valid)
    else $error("status read answered without drain");
  a_cond_cmp: assert property (res_valid && res_cmp_valid && !ctl_wr_en
    |=> cond_out == $past(res_cmp))
    else $error("condition bit not taken from compare");
  a_round_write: assert property (ctl_wr_en && ctl_wr_addr == 5'h1f
    |=> round_mode == $past(ctl_wr_data[1:0]))
    else $error("rounding mode not written");
endmodule

bind frf_top frf_top_asserts #(.IMPL_CODE(IMPL_CODE), .REV_CODE(REV_CODE)) frf_top_asserts_inst (
  .mclk, .rst, .gr_rd_en, .gr_rd_valid, .op_issue, .op_ready, .op_fmt, .op_src_a,
  .op_src_b, .opa_data, .opb_data, .op_valid, .pair_addr_err, .res_valid, .res_cmp_valid,
  .res_cmp, .ctl_wr_en, .ctl_wr_addr, .ctl_wr_data, .ctl_rd_en, .ctl_rd_addr, .ctl_rd_data,
  .ctl_rd_valid, .ctl_busy, .round_mode, .cond_out
);

// ==== test/frf_core_model.sv ====
// Model of the execution side that retires every accepted operation.
// Assumes the bench issues operations; results come back after lat cycles.
module frf_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Issue as the design sees it
  input wire logic op_issue,
  input wire logic op_ready,
  input wire frf_pkg::frf_fmt_t op_fmt,
  input wire logic [4:0] op_src_a,
  input wire logic [4:0] op_src_b,
  // Latency, result word and exception causes chosen by the bench
  input wire logic [7:0] lat,
  input wire logic [63:0] word,
  input wire logic [5:0] exc,
  // Result strobe into the design
  output logic res_valid,
  output frf_pkg::frf_fmt_t res_fmt,
  output logic [4:0] res_dst,
  output logic [63:0] res_data,
  output logic [5:0] res_exc
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int due [$];
  logic [5:0] job [$];
  logic [5:0] j;
  initial
  begin
    res_valid = 1'b0;
    res_fmt = frf_pkg::FRF_FMT_SINGLE;
    res_dst = 5'h00;
    res_data = 64'h0;
    res_exc = 6'h00;
  end
  always @(posedge mclk)
  begin
    cyc++;
    // Odd pair numbers are never sent on to execution.
    if (!rst && op_issue && op_ready && !op_src_a[0] && !op_src_b[0])
    begin
      due.push_back(cyc + int'(lat));
      job.push_back({op_fmt, op_src_a});
    end
    if (!rst && due.size() > 0 && due[0] <= cyc)
    begin
      j = job.pop_front();
      void'(due.pop_front());
      res_valid <= 1'b1;
      res_fmt <= frf_pkg::frf_fmt_t'(j[5]);
      res_dst <= j[4:0];
      res_data <= word;
      res_exc <= exc;
    end
    else
    begin
      // Idle destination and data lines keep changing so a stale value is never mistaken for data.
      res_valid <= 1'b0;
      res_dst <= ~res_dst;
      res_data <= ~res_data;
    end
  end
endmodule

// ==== test/frf_top_bench.sv ====
// Self-checking bench for the floating-point register file top.
// Assumes the checker is bound in and the core model retires operations.
module frf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Identification codes; the values are arbitrary.
  localparam logic [7:0] IMPL = 8'h3c;
  localparam logic [7:0] REV = 8'h07;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic gr_wr_en = 1'b0, gr_rd_en = 1'b0, op_issue = 1'b0, ctl_wr_en = 1'b0, ctl_rd_en = 1'b0;
  logic res_cmp_valid = 1'b0, res_cmp = 1'b0;
  logic [4:0] gr_wr_addr = '0, gr_rd_addr = '0, op_src_a = '0, op_src_b = '0;
  logic [4:0] ctl_wr_addr = '0, ctl_rd_addr = '0;
  logic [31:0] gr_wr_data = '0, ctl_wr_data = '0;
  logic [63:0] word = '0;
  logic [7:0] lat = 8'd1;
  frf_pkg::frf_fmt_t op_fmt = frf_pkg::FRF_FMT_SINGLE;
  frf_pkg::frf_fmt_t res_fmt;
  logic gr_rd_valid, op_ready, op_valid, res_valid, ctl_rd_valid, ctl_rd_abort, ctl_busy;
  logic pair_addr_err, cond_out, fp_trap, ov, er, ab;
  logic [5:0] exc = '0;
  logic [4:0] res_dst;
  logic [5:0] res_exc;
  logic [1:0] round_mode;
  logic [31:0] gr_rd_data, ctl_rd_data;
  logic [63:0] opa_data, opb_data, res_data;
  logic [31:0] expv [32];
  int mismatches = 0;
  int total_checks = 0;
  always #10 mclk = ~mclk;
  frf_top #(.IMPL_CODE(IMPL), .REV_CODE(REV)) frf_top_inst (
    .mclk, .rst, .gr_wr_en, .gr_wr_addr, .gr_wr_data, .gr_rd_en, .gr_rd_addr, .gr_rd_data,
    .gr_rd_valid, .op_issue, .op_fmt, .op_src_a, .op_src_b, .op_ready, .opa_data, .opb_data,
    .op_valid, .res_valid, .res_fmt, .res_dst, .res_data, .res_exc, .res_cmp_valid, .res_cmp,
    .ctl_wr_en, .ctl_wr_addr, .ctl_wr_data, .ctl_rd_en, .ctl_rd_addr, .ctl_rd_data,
    .ctl_rd_valid, .ctl_rd_abort, .ctl_busy, .pair_addr_err, .round_mode, .cond_out, .fp_trap
  );
  frf_core_model frf_core_model_inst (
    .mclk, .rst, .op_issue, .op_ready, .op_fmt, .op_src_a, .op_src_b, .lat, .word, .exc,
    .res_valid, .res_fmt, .res_dst, .res_data, .res_exc
  );
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [4:0] a);
    gr_rd_en <= 1'b1;
    gr_rd_addr <= a;
    @(posedge mclk);
    gr_rd_en <= 1'b0;
    @(negedge mclk);
    chk("gr_rd_valid", 64'h1, {63'h0, gr_rd_valid});
    chk("gr_rd_data", {32'h0, expv[a]}, {32'h0, gr_rd_data});
    @(posedge mclk);
  endtask
  task automatic issue(input frf_pkg::frf_fmt_t f, input logic [4:0] a, input logic [4:0] b);
    op_issue <= 1'b1;
    op_fmt <= f;
    op_src_a <= a;
    op_src_b <= b;
    @(posedge mclk);
    op_issue <= 1'b0;
    @(negedge mclk);
    ov = op_valid;
    er = pair_addr_err;
    @(posedge mclk);
  endtask
  task automatic ctl_wr(input logic [4:0] a, input logic [31:0] d);
    ctl_wr_en <= 1'b1;
    ctl_wr_addr <= a;
    ctl_wr_data <= d;
    @(posedge mclk);
    ctl_wr_en <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic ctl_rd(input logic [4:0] a, output logic [31:0] d, output int n);
    ctl_rd_en <= 1'b1;
    ctl_rd_addr <= a;
    @(posedge mclk);
    ctl_rd_en <= 1'b0;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (ctl_rd_valid !== 1'b1 && ctl_rd_abort !== 1'b1 && n < 100);
    d = ctl_rd_data;
    ab = ctl_rd_abort;
    @(posedge mclk);
  endtask
  task automatic t_gr();
    for (int k = 0; k < 32; k++)
    begin
      expv[k] = 32'h1000_0000 + 32'(k) * 32'h0101_0001;
      gr_wr_en <= 1'b1;
      gr_wr_addr <= 5'(k);
      gr_wr_data <= expv[k];
      @(posedge mclk);
    end
    gr_wr_en <= 1'b0;
    for (int k = 0; k < 32; k++)
      rdchk(5'(k));
    $display("t_gr done");
  endtask
  task automatic t_pair();
    res_cmp_valid <= 1'b1;
    for (int n = 0; n < 32; n += 2)
    begin
      issue(frf_pkg::FRF_FMT_DOUBLE, 5'(n), 5'(30 - n));
      chk("op_valid", 64'h1, {63'h0, ov});
      chk("opa double", {expv[n + 1], expv[n]}, opa_data);
      chk("opb double", {expv[31 - n], expv[30 - n]}, opb_data);
      issue(frf_pkg::FRF_FMT_SINGLE, 5'(n), 5'(n));
      chk("opa single", {32'h0, expv[n]}, opa_data);
    end
    issue(frf_pkg::FRF_FMT_DOUBLE, 5'h03, 5'h00);
    chk("odd refused", 64'h2, {62'h0, er, ov});
    res_cmp_valid <= 1'b0;
    $display("t_pair done");
  endtask
  task automatic t_res();
    lat <= 8'd2;
    word <= 64'hdead_beef_0123_4567;
    issue(frf_pkg::FRF_FMT_SINGLE, 5'h04, 5'h00);
    issue(frf_pkg::FRF_FMT_DOUBLE, 5'h06, 5'h00);
    repeat (4) @(posedge mclk);
    expv[4] = 32'h0123_4567;
    expv[6] = 32'h0123_4567;
    expv[7] = 32'hdead_beef;
    for (int k = 4; k < 8; k++)
      rdchk(5'(k));
    $display("t_res done");
  endtask
  task automatic t_ctl();
    logic [31:0] d;
    int n;
    ctl_wr(5'h1f, 32'hffff_ffff);
    chk("round_mode", 64'h3, {62'h0, round_mode});
    chk("fp_trap set", 64'h1, {63'h0, fp_trap});
    ctl_rd(5'h1f, d, n);
    chk("status", 64'h0083_ffff, {32'h0, d});
    chk("cond_out", 64'h1, {63'h0, cond_out});
    ctl_rd(5'h00, d, n);
    chk("identity", {48'h0, IMPL, REV}, {32'h0, d});
    ctl_wr(5'h05, 32'h1234_5678);
    ctl_rd(5'h05, d, n);
    chk("unused control", 64'h0, {32'h0, d});
    ctl_wr(5'h1f, 32'h0000_0002);
    chk("round_mode", 64'h2, {62'h0, round_mode});
    chk("fp_trap clear", 64'h0, {63'h0, fp_trap});
    $display("t_ctl done");
  endtask
  task automatic t_drain();
    logic [31:0] d;
    int n;
    lat <= 8'd20;
    res_cmp_valid <= 1'b1;
    res_cmp <= 1'b1;
    issue(frf_pkg::FRF_FMT_DOUBLE, 5'h00, 5'h02);
    ctl_rd(5'h1f, d, n);
    chk("drain wait", 64'h1, {63'h0, n > 15});
    chk("status after compare", 64'h0080_0002, {32'h0, d});
    // An unimplemented-operation result while emptying abandons the status read.
    exc <= 6'h20;
    issue(frf_pkg::FRF_FMT_DOUBLE, 5'h00, 5'h02);
    ctl_rd(5'h1f, d, n);
    chk("read abort", 64'h1, {63'h0, ab});
    chk("fp_trap unimpl", 64'h1, {63'h0, fp_trap});
    // Fifteen outstanding operations fill the count and stop further issue.
    lat <= 8'd60;
    for (int k = 0; k < 15; k++)
      issue(frf_pkg::FRF_FMT_SINGLE, 5'h00, 5'h00);
    chk("op_ready full", 64'h0, {63'h0, op_ready});
    repeat (80) @(posedge mclk);
    chk("op_ready free", 64'h1, {63'h0, op_ready});
    res_cmp_valid <= 1'b0;
    $display("t_drain done");
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_gr();
    t_pair();
    t_res();
    t_ctl();
    t_drain();
    end_of_test();
  end
endmodule
